// file: logic/synth_ctrl_defines.svh
`ifndef SYNTH_CTRL_DEFINES_SVH
`define SYNTH_CTRL_DEFINES_SVH

// Register indices
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_POWER 4'h2
`define REG_MODE 4'h3
`define REG_REGULATOR 4'h4
`define REG_SEED 4'h5
`define REG_NDIV_HI 4'h6
`define REG_NDIV_LO 4'h7
`define REG_NUM_HI 4'h8
`define REG_NUM_MID 4'h9
`define REG_NUM_LO 4'hA
`define REG_OUTDIV 4'hB
`define REG_PUMP 4'hC
`define REG_PUMP_FN 4'hD
`define REG_ID 4'hE
`define REG_LAST 7'h0E
`define AUTO_FIRST 4'h5
`define AUTO_LAST 4'hA

// Reset values
`define RST_MASK 8'h04
`define RST_POWER 8'h06
`define RST_MODE 8'h3E
`define RST_REGULATOR 8'h47
`define RST_SEED 8'h11
`define RST_NDIV_HI 8'h08
`define RST_NDIV_LO 8'hFA
`define RST_NUM_HI 8'h3F
`define RST_NUM_MID 8'hFF
`define RST_NUM_LO 8'hF0
`define RST_OUTDIV 8'hF9
`define RST_PUMP 8'h4F
`define RST_PUMP_FN 8'hE4

// Writable bits of registers with unused positions
`define WMASK_MASK 8'h3F
`define WMASK_NDIV_HI 8'hFB
`define WMASK_NUM_HI 8'h3F
`define WMASK_NUM_LO 8'hF3

// Field positions
`define BIT_POWER_OFF 3
`define BIT_SILENCE 1
`define BIT_ALWAYS_ON 7
`define BIT_MONITOR 6
`define BIT_DURING_TUNE 5
`define BIT_WHEN_UNLOCKED 4
`define BIT_REINIT_AUTO 2
`define BIT_DITHER 1
`define BIT_INTEGER 0
`define BIT_REG_ON 2
`define BIT_REINIT 1
`define BIT_CAL 0
`define BIT_ST_LOCK 2
`define BIT_ST_HIGH 4
`define BIT_ST_LOW 3

// Output divider limits
`define OD_MIN 3'h1
`define OD_MAX 3'h6

`endif

// file: logic/synth_ctrl_pkg.sv
`default_nettype none
package synth_ctrl_pkg;
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ = 2'b10
  } spi_phase_e;
  typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// file: logic/dither_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
module dither_lfsr #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic load, // Load seed
  input wire logic [WIDTH-1:0] seed, // Starting state
  input wire logic step, // Advance one state
  output logic [WIDTH-1:0] state_q // Current state
);
  if (WIDTH != 8) begin : g_check
    $error("dither_lfsr supports WIDTH 8 only");
  end

  logic fb;
  assign fb = state_q[7] ^ state_q[5] ^ state_q[4] ^ state_q[3];

  // All-zero seed would lock up, so it loads as one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= 8'h01;
    end else if (load) begin
      state_q <= (seed == '0) ? 8'h01 : seed;
    end else if (step) begin
      state_q <= {state_q[6:0], fb};
    end
  end
endmodule // dither_lfsr
`default_nettype wire

// file: logic/synth_spi_control_modulator.sv
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defines.svh"
module synth_spi_control_modulator #(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identity byte
) (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic spi_cs_n, // Chip select pin
  input wire logic spi_sclk, // Serial clock pin
  input wire logic spi_sdi, // Serial data in
  output logic spi_sdo_q, // Serial data out
  output logic spi_sdo_oe_q, // Serial out enable
  input wire logic pfd_clk, // Phase-detector rate clock
  input wire logic rf_mute_n, // External mute, active low
  input wire logic [5:0] status_raw, // Unlock,high,low,lock,clamp hi,clamp lo
  input wire logic cal_busy, // Calibration running, same clock
  output logic amp_loop_on_q, // Amplitude loop active
  output logic amp_correct_q, // Amplitude correction applied
  output logic amp_flags_valid_q, // High/low flags meaningful
  output logic stat_q, // Status pin
  output logic rf_mute_q, // Output buffer mute
  output logic reg_enable_q, // Regulator running
  output logic reg_bypass_q, // Regulator bypassed
  output logic [1:0] reg_level_q, // Regulator level code
  output logic [2:0] out_div_q, // Output divide ratio
  output logic [9:0] fb_ratio_q, // Feedback ratio this PFD cycle
  output logic mod_standby_q, // Modulator in standby
  output logic cal_start_q // Calibration start pulse
);
  localparam int REG_COUNT = 15;
  localparam int SYNC_W = 11;
  if (REG_COUNT != 15) begin : g_check
    $error("register count must be 15");
  end

  function automatic logic [7:0] reset_value(input logic [3:0] idx);
    unique case (idx)
      `REG_MASK: reset_value = `RST_MASK;
      `REG_POWER: reset_value = `RST_POWER;
      `REG_MODE: reset_value = `RST_MODE;
      `REG_REGULATOR: reset_value = `RST_REGULATOR;
      `REG_SEED: reset_value = `RST_SEED;
      `REG_NDIV_HI: reset_value = `RST_NDIV_HI;
      `REG_NDIV_LO: reset_value = `RST_NDIV_LO;
      `REG_NUM_HI: reset_value = `RST_NUM_HI;
      `REG_NUM_MID: reset_value = `RST_NUM_MID;
      `REG_NUM_LO: reset_value = `RST_NUM_LO;
      `REG_OUTDIV: reset_value = `RST_OUTDIV;
      `REG_PUMP: reset_value = `RST_PUMP;
      `REG_PUMP_FN: reset_value = `RST_PUMP_FN;
      default: reset_value = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] write_mask(input logic [3:0] idx);
    unique case (idx)
      `REG_STATUS, `REG_ID: write_mask = 8'h00;
      `REG_MASK: write_mask = `WMASK_MASK;
      `REG_NDIV_HI: write_mask = `WMASK_NDIV_HI;
      `REG_NUM_HI: write_mask = `WMASK_NUM_HI;
      `REG_NUM_LO: write_mask = `WMASK_NUM_LO;
      default: write_mask = 8'hFF;
    endcase
  endfunction

  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    next_ptr = (p >= `REG_LAST) ? 7'h00 : p + 7'h01;
  endfunction

  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 11'h001;
      sync2_q <= 11'h001;
    end else begin
      sync1_q <= {status_raw, rf_mute_n, pfd_clk, spi_sdi, spi_sclk, spi_cs_n};
      sync2_q <= sync1_q;
    end
  end

  logic cs_n_s, sclk_s, sdi_s, pfd_s, mute_n_s;
  logic [5:0] status_s;
  assign cs_n_s = sync2_q[0];
  assign sclk_s = sync2_q[1];
  assign sdi_s = sync2_q[2];
  assign pfd_s = sync2_q[3];
  assign mute_n_s = sync2_q[4];
  assign status_s = sync2_q[10:5];

  logic sclk_prev_q, pfd_prev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      pfd_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
      pfd_prev_q <= pfd_s;
    end
  end

  logic sclk_rise, pfd_tick;
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign pfd_tick = pfd_s & ~pfd_prev_q;

  // Serial framing
  synth_ctrl_pkg::spi_phase_e phase_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_shift_q;
  logic [6:0] ptr_q;
  logic [7:0] rx_byte;
  logic byte_done, wr_commit;
  assign rx_byte = {rx_shift_q, sdi_s};
  assign byte_done = sclk_rise & (bit_cnt_q == 3'h7);
  assign wr_commit = byte_done & (phase_q == synth_ctrl_pkg::PH_WRITE) & (ptr_q <= `REG_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= synth_ctrl_pkg::PH_ADDR;
      bit_cnt_q <= 3'h0;
      rx_shift_q <= 7'h00;
      ptr_q <= 7'h00;
    end else if (cs_n_s) begin
      phase_q <= synth_ctrl_pkg::PH_ADDR;
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      rx_shift_q <= rx_byte[6:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        unique case (phase_q)
          synth_ctrl_pkg::PH_ADDR: begin
            ptr_q <= rx_byte[7:1];
            phase_q <= rx_byte[0] ? synth_ctrl_pkg::PH_READ : synth_ctrl_pkg::PH_WRITE;
          end
          synth_ctrl_pkg::PH_WRITE, synth_ctrl_pkg::PH_READ: begin
            ptr_q <= next_ptr(ptr_q);
          end
          default: begin
            phase_q <= synth_ctrl_pkg::PH_ADDR;
          end
        endcase
      end
    end
  end

  // Register file
  synth_ctrl_pkg::reg_byte_t regs_q [REG_COUNT];
  logic [5:0] status_q;
  logic auto_hit;
  assign auto_hit = wr_commit & regs_q[`REG_MODE][`BIT_REINIT_AUTO]
                    & (ptr_q[3:0] >= `AUTO_FIRST) & (ptr_q[3:0] <= `AUTO_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= reset_value(4'(i));
      end
    end else begin
      if (regs_q[`REG_NUM_LO][`BIT_REINIT]) begin
        regs_q[`REG_NUM_LO][`BIT_REINIT] <= 1'b0;
      end
      if (regs_q[`REG_NUM_LO][`BIT_CAL]) begin
        regs_q[`REG_NUM_LO][`BIT_CAL] <= 1'b0;
      end
      if (wr_commit) begin
        regs_q[ptr_q[3:0]] <= (rx_byte & write_mask(ptr_q[3:0]))
                              | (regs_q[ptr_q[3:0]] & ~write_mask(ptr_q[3:0]));
      end
      if (auto_hit) begin
        regs_q[`REG_NUM_LO][`BIT_REINIT] <= 1'b1;
      end
    end
  end

  // Read data for the byte about to be shifted out
  logic [6:0] tx_addr;
  logic [7:0] rd_data;
  assign tx_addr = (phase_q == synth_ctrl_pkg::PH_ADDR) ? rx_byte[7:1] : next_ptr(ptr_q);
  always_comb begin
    rd_data = 8'h00;
    if (tx_addr == 7'(`REG_STATUS)) begin
      rd_data = {2'b00, status_q};
    end else if (tx_addr == `REG_LAST) begin
      rd_data = ID_CODE;
    end else if (tx_addr < `REG_LAST) begin
      rd_data = regs_q[tx_addr[3:0]];
    end
  end

  // Serial output
  logic [7:0] tx_shift_q;
  logic read_start;
  assign read_start = byte_done & (((phase_q == synth_ctrl_pkg::PH_ADDR) & rx_byte[0])
                                   | (phase_q == synth_ctrl_pkg::PH_READ));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_q <= 8'h00;
      spi_sdo_q <= 1'b0;
      spi_sdo_oe_q <= 1'b0;
    end else if (cs_n_s) begin
      spi_sdo_q <= 1'b0;
      spi_sdo_oe_q <= 1'b0;
    end else if (read_start) begin
      tx_shift_q <= rd_data;
      spi_sdo_q <= rd_data[7];
      spi_sdo_oe_q <= 1'b1;
    end else if (sclk_rise && phase_q == synth_ctrl_pkg::PH_READ) begin
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      spi_sdo_q <= tx_shift_q[6];
    end
  end

  // Amplitude loop control and status capture
  logic [7:0] mode;
  logic amp_active, flags_valid;
  assign mode = regs_q[`REG_MODE];
  assign amp_active = mode[`BIT_ALWAYS_ON]
                      | (mode[`BIT_DURING_TUNE] & cal_busy)
                      | (mode[`BIT_WHEN_UNLOCKED] & ~status_s[`BIT_ST_LOCK]);
  assign flags_valid = amp_active | mode[`BIT_MONITOR];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_loop_on_q <= 1'b0;
      amp_correct_q <= 1'b0;
      amp_flags_valid_q <= 1'b0;
    end else begin
      amp_loop_on_q <= amp_active;
      amp_correct_q <= amp_active;
      amp_flags_valid_q <= flags_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 6'h00;
      stat_q <= 1'b0;
    end else begin
      status_q[5] <= status_s[5];
      status_q[2:0] <= status_s[2:0];
      if (flags_valid) begin
        status_q[`BIT_ST_HIGH] <= status_s[`BIT_ST_HIGH];
        status_q[`BIT_ST_LOW] <= status_s[`BIT_ST_LOW];
      end
      stat_q <= |(status_q & regs_q[`REG_MASK][5:0]);
    end
  end

  // Regulator, output divider, mute, calibration start
  logic [2:0] od_field;
  assign od_field = regs_q[`REG_OUTDIV][2:0];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_enable_q <= 1'b0;
      reg_bypass_q <= 1'b1;
      reg_level_q <= 2'h0;
      out_div_q <= `OD_MIN;
      rf_mute_q <= 1'b1;
      cal_start_q <= 1'b0;
    end else begin
      reg_enable_q <= regs_q[`REG_REGULATOR][`BIT_REG_ON] & ~regs_q[`REG_POWER][`BIT_POWER_OFF];
      reg_bypass_q <= ~regs_q[`REG_REGULATOR][`BIT_REG_ON] | regs_q[`REG_POWER][`BIT_POWER_OFF];
      reg_level_q <= regs_q[`REG_REGULATOR][1:0];
      out_div_q <= (od_field < `OD_MIN) ? `OD_MIN : (od_field > `OD_MAX) ? `OD_MAX : od_field;
      rf_mute_q <= regs_q[`REG_POWER][`BIT_SILENCE] | ~mute_n_s;
      cal_start_q <= regs_q[`REG_NUM_LO][`BIT_CAL];
    end
  end

  // Fractional modulator
  logic [9:0] n_div;
  logic [17:0] num;
  logic [17:0] acc_q;
  logic [7:0] lfsr_state;
  logic reinit, integer_mode, dither_en;
  logic [18:0] mod_sum;
  assign n_div = {regs_q[`REG_NDIV_HI][1:0], regs_q[`REG_NDIV_LO]};
  assign num = {regs_q[`REG_NUM_HI][5:0], regs_q[`REG_NUM_MID], regs_q[`REG_NUM_LO][7:4]};
  assign reinit = regs_q[`REG_NUM_LO][`BIT_REINIT];
  assign integer_mode = mode[`BIT_INTEGER];
  assign dither_en = mode[`BIT_DITHER];
  // Zero-mean dither in the LSB keeps the average fraction exact
  assign mod_sum = {1'b0, acc_q} + {1'b0, num} + {18'h0_0000, dither_en & lfsr_state[0]}
                   - {18'h0_0000, dither_en & lfsr_state[1]};

  dither_lfsr #(.WIDTH(8)) u_dither (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(reinit),
    .seed(regs_q[`REG_SEED]),
    .step(pfd_tick & ~integer_mode),
    .state_q(lfsr_state)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= 18'h0_0000;
      fb_ratio_q <= 10'h000;
      mod_standby_q <= 1'b0;
    end else begin
      mod_standby_q <= integer_mode;
      if (reinit) begin
        acc_q <= 18'h0_0000;
      end else if (pfd_tick && !integer_mode) begin
        acc_q <= mod_sum[17:0];
      end
      if (pfd_tick) begin
        fb_ratio_q <= integer_mode ? n_div : n_div + {9'h000, mod_sum[18]};
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_always_on;
    mode[`BIT_ALWAYS_ON] |=> amp_loop_on_q && amp_correct_q;
  endproperty
  a_always_on: assert property (p_always_on) else $error("loop not on with always-on");

  property p_tune;
    mode[`BIT_DURING_TUNE] && cal_busy |=> amp_loop_on_q;
  endproperty
  a_tune: assert property (p_tune) else $error("loop not on during tune");

  property p_unlocked;
    mode[`BIT_WHEN_UNLOCKED] && !status_s[`BIT_ST_LOCK] |=> amp_loop_on_q;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("loop not on while unlocked");

  property p_monitor;
    mode[`BIT_MONITOR] && !amp_active |=> !amp_correct_q && amp_flags_valid_q;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor-only applied correction");

  property p_mute;
    !mute_n_s |=> rf_mute_q;
  endproperty
  a_mute: assert property (p_mute) else $error("output not muted");

  sequence s_deselect;
    cs_n_s ##1 cs_n_s;
  endsequence
  property p_release;
    s_deselect |-> !spi_sdo_oe_q;
  endproperty
  a_release: assert property (p_release) else $error("serial out driven while deselected");

  property p_reinit;
    reinit |=> (acc_q == 18'h0_0000) ##1 (!reinit || $past(auto_hit) || $past(wr_commit));
  endproperty
  a_reinit: assert property (p_reinit) else $error("modulator reinit misbehaved");

  property p_auto;
    auto_hit |=> reinit ##1 (acc_q == 18'h0_0000);
  endproperty
  a_auto: assert property (p_auto) else $error("auto reinit missing");

  property p_stat;
    |(status_q & regs_q[`REG_MASK][5:0]) |=> stat_q;
  endproperty
  a_stat: assert property (p_stat) else $error("status pin low with masked flag");

  property p_regulator;
    !regs_q[`REG_REGULATOR][`BIT_REG_ON] |=> reg_bypass_q && !reg_enable_q;
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator not bypassed");

  property p_integer;
    pfd_tick && integer_mode && !reinit |=> fb_ratio_q == $past(n_div) && $stable(acc_q);
  endproperty
  a_integer: assert property (p_integer) else $error("integer mode ratio wrong");
endmodule // synth_spi_control_modulator
`default_nettype wire

// file: tb/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  input wire logic sys_clk, // Bench clock, for alignment only
  input wire logic sdo_wire, // Resolved serial out line
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock, idles low
  output logic sdi // Serial data to the device
);
  logic [7:0] dat [16];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Data changes while the clock is low, read data taken on the rise
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sdi = tx[i];
      #24 sclk = 1'b1;
      rx[i] = sdo_wire;
      #24 sclk = 1'b0;
    end
  endtask

  // Address byte, n whole bytes, then tail bits of a cut byte
  task automatic burst(input logic [6:0] addr, input logic rd, input int n, input int tail);
    logic [7:0] rx;
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
    #24;
    shift({addr, rd}, 8, rx);
    for (int b = 0; b < n; b++) begin
      shift(dat[b], 8, rx);
      if (rd) begin
        dat[b] = rx;
      end
    end
    if (tail > 0) begin
      shift(8'h5A, tail, rx);
    end
    cs_n = 1'b1;
    sdi = ~sdi;
    #48;
  endtask
endmodule // spi_master_model
`default_nettype wire

// file: tb/synth_spi_control_modulator_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "synth_ctrl_defines.svh"
module synth_spi_control_modulator_test;
  localparam logic [7:0] ID_ARB = 8'hC3; // Arbitrary identity byte
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pfd_clk = 1'b0;
  logic rf_mute_n = 1'b1;
  logic cal_busy = 1'b0;
  logic [5:0] status_raw = 6'h04;
  logic spi_sdo_q, spi_sdo_oe_q, amp_loop_on_q, amp_correct_q, amp_flags_valid_q, stat_q, rf_mute_q;
  logic reg_enable_q, reg_bypass_q, mod_standby_q, cal_start_q;
  logic [1:0] reg_level_q;
  logic [2:0] out_div_q;
  logic [9:0] fb_ratio_q;
  wire spi_cs_n, spi_sclk, spi_sdi, sdo_wire;
  int errors = 0;
  int num_checks = 0;
  int cal_pulses = 0;

  always #2 sys_clk = ~sys_clk;

  // Counts calibration start pulses seen on the output
  always @(posedge sys_clk) begin
    if (cal_start_q === 1'b1) begin
      cal_pulses++;
    end
  end
  assign sdo_wire = spi_sdo_oe_q ? spi_sdo_q : 1'b0; // Pull-down on released line

  synth_spi_control_modulator #(.ID_CODE(ID_ARB)) synth_spi_control_modulator_inst (
    .sys_clk, .rst_n, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo_q, .spi_sdo_oe_q, .pfd_clk,
    .rf_mute_n, .status_raw, .cal_busy, .amp_loop_on_q, .amp_correct_q, .amp_flags_valid_q,
    .stat_q, .rf_mute_q, .reg_enable_q, .reg_bypass_q, .reg_level_q, .out_div_q, .fb_ratio_q,
    .mod_standby_q, .cal_start_q);

  spi_master_model spi_master_model_inst (.sys_clk(sys_clk), .sdo_wire(sdo_wire),
    .cs_n(spi_cs_n), .sclk(spi_sclk), .sdi(spi_sdi));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_master_model_inst.dat[0] = d;
    spi_master_model_inst.burst(a, 1'b0, 1, 0);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    spi_master_model_inst.dat[0] = 8'hFF;
    spi_master_model_inst.burst(a, 1'b1, 1, 0);
    d = spi_master_model_inst.dat[0];
  endtask

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole map from h01, running on through h0E and wrapping to h00
  task automatic test_reset;
    logic [7:0] exp [15];
    exp = '{`RST_MASK, `RST_POWER, `RST_MODE, `RST_REGULATOR, `RST_SEED, `RST_NDIV_HI, `RST_NDIV_LO,
      `RST_NUM_HI, `RST_NUM_MID, `RST_NUM_LO, `RST_OUTDIV, `RST_PUMP, `RST_PUMP_FN, ID_ARB, 8'h04};
    for (int i = 0; i < 16; i++) spi_master_model_inst.dat[i] = 8'hFF;
    spi_master_model_inst.burst(7'h01, 1'b1, 15, 0);
    for (int i = 0; i < 15; i++) check_val(16'(spi_master_model_inst.dat[i]), 16'(exp[i]));
    check_val(16'({rf_mute_q, reg_enable_q, reg_bypass_q, reg_level_q, out_div_q, mod_standby_q}),
      16'h01B2);
    check_val(16'(spi_sdo_oe_q), 16'h0000);
    $display("test_reset done");
  endtask

  // Read-only places, unused bits and self-clearing bits
  task automatic test_access;
    logic [6:0] a [5];
    logic [7:0] d [5];
    logic [7:0] e [5];
    logic [7:0] got;
    a = '{7'h01, 7'h00, 7'h0E, 7'h06, 7'h0A};
    d = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h0F};
    e = '{8'h3F, 8'h04, ID_ARB, 8'hFB, 8'h00};
    for (int i = 0; i < 5; i++) wr(a[i], d[i]);
    check_val(16'(cal_pulses), 16'h0001);
    for (int i = 0; i < 5; i++) begin
      rd(a[i], got);
      check_val(16'(got), 16'(e[i]));
    end
    $display("test_access done");
  endtask

  // Write wrapping past h0E, then a byte cut short
  task automatic test_wrap;
    spi_master_model_inst.dat[0] = 8'h11;
    spi_master_model_inst.dat[1] = 8'h22;
    spi_master_model_inst.dat[2] = 8'h33;
    spi_master_model_inst.dat[3] = 8'hC4;
    spi_master_model_inst.burst(7'h0D, 1'b0, 4, 0);
    spi_master_model_inst.burst(7'h0D, 1'b1, 4, 0);
    check_val(16'(spi_master_model_inst.dat[0]), 16'h0011);
    check_val(16'(spi_master_model_inst.dat[1]), 16'(ID_ARB));
    check_val(16'(spi_master_model_inst.dat[2]), 16'h0004);
    check_val(16'(spi_master_model_inst.dat[3]), 16'h0004);
    spi_master_model_inst.burst(7'h05, 1'b0, 0, 5);
    spi_master_model_inst.burst(7'h05, 1'b1, 1, 0);
    check_val(16'(spi_master_model_inst.dat[0]), 16'(`RST_SEED));
    $display("test_wrap done");
  endtask

  task automatic test_stat;
    wr(7'h03, 8'h64);
    for (int i = 0; i < 6; i++) begin
      wr(7'h01, 8'(1 << i));
      status_raw = 6'(1 << i);
      tick(10);
      check_val(16'(stat_q), 16'h0001);
      status_raw = ~6'(1 << i);
      tick(10);
      check_val(16'(stat_q), 16'h0000);
    end
    $display("test_stat done");
  endtask

  // Entry: mode byte, calibration busy, lock, loop on, flags valid
  task automatic test_amp;
    logic [11:0] t [7];
    logic [7:0] got;
    t = '{12'h807, 12'hF07, 12'h20F, 12'h204, 12'h103, 12'h104, 12'h605};
    for (int i = 0; i < 7; i++) begin
      wr(7'h03, t[i][11:4]);
      cal_busy = t[i][3];
      status_raw = {3'b000, t[i][2], 2'b00};
      tick(10);
      check_val(16'({amp_loop_on_q, amp_correct_q, amp_flags_valid_q}),
        16'({t[i][1], t[i][1], t[i][0]}));
    end
    status_raw = 6'h14;
    tick(10);
    rd(7'h00, got);
    check_val(16'(got), 16'h0014);
    cal_busy = 1'b0;
    status_raw = 6'h04;
    $display("test_amp done");
  endtask

  task automatic test_power;
    wr(7'h02, 8'h02);
    check_val(16'(rf_mute_q), 16'h0001);
    wr(7'h02, 8'h00);
    check_val(16'(rf_mute_q), 16'h0000);
    rf_mute_n = 1'b0;
    tick(10);
    check_val(16'(rf_mute_q), 16'h0001);
    rf_mute_n = 1'b1;
    for (int lv = 0; lv < 4; lv++) begin
      wr(7'h04, 8'h44 | 8'(lv));
      check_val(16'({reg_enable_q, reg_bypass_q, reg_level_q}), 16'(8 | lv));
    end
    wr(7'h04, 8'h43);
    check_val(16'({reg_enable_q, reg_bypass_q}), 16'h0001);
    wr(7'h04, 8'h47);
    wr(7'h02, 8'h08);
    check_val(16'({reg_enable_q, reg_bypass_q}), 16'h0001);
    wr(7'h02, 8'h00);
    for (int od = 0; od < 8; od++) begin
      wr(7'h0B, 8'hF8 | 8'(od));
      check_val(16'(out_div_q), (od == 0) ? 16'h0001 : (od == 7) ? 16'h0006 : 16'(od));
    end
    $display("test_power done");
  endtask

  task automatic setnum(input logic [9:0] n, input logic [17:0] num);
    logic [7:0] b [5];
    b = '{{6'h00, n[9:8]}, n[7:0], {2'b00, num[17:12]}, num[11:4], {num[3:0], 4'h0}};
    for (int i = 0; i < 5; i++) spi_master_model_inst.dat[i] = b[i];
    spi_master_model_inst.burst(7'h06, 1'b0, 5, 0);
  endtask

  task automatic pfd(input int n, output logic [15:0] sum);
    sum = 16'h0000;
    repeat (n) begin
      pfd_clk = 1'b1;
      tick(4);
      pfd_clk = 1'b0;
      tick(4);
      sum = sum + 16'(fb_ratio_q);
    end
  endtask

  task automatic test_mod;
    logic [15:0] s;
    logic [7:0] got;
    wr(7'h03, 8'h25);
    check_val(16'(mod_standby_q), 16'h0001);
    setnum(10'h020, 18'h0_0000);
    pfd(1, s);
    check_val(s, 16'h0020);
    setnum(10'h3FF, 18'h0_0000);
    pfd(1, s);
    check_val(s, 16'h03FF);
    wr(7'h03, 8'h24);
    check_val(16'(mod_standby_q), 16'h0000);
    setnum(10'h064, 18'h2_0000);
    pfd(8, s);
    check_val(s, 16'h0324);
    pfd(3, s);
    wr(7'h05, 8'h11);
    pfd(1, s);
    check_val(s, 16'h0064);
    wr(7'h03, 8'h20);
    wr(7'h05, 8'h11);
    pfd(1, s);
    check_val(s, 16'h0065);
    pfd(1, s);
    wr(7'h0A, 8'h02);
    pfd(1, s);
    check_val(s, 16'h0064);
    rd(7'h0A, got);
    check_val(16'(got), 16'h0000);
    $display("test_mod done");
  endtask

  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(4);
    test_reset();
    test_access();
    test_wrap();
    test_stat();
    test_amp();
    test_power();
    test_mod();
    print_verdict();
  end

  initial begin
    #200000;
    errors++;
    print_verdict();
  end
endmodule // synth_spi_control_modulator_test
`default_nettype wire
